// File: verilog/pursq_pkg.sv
// Constants and types shared by the power-up reset sequencer
package pursq_pkg;

  // Clock and time figures
  localparam int CLK_PERIOD_NS = 40;
  localparam int POR_PULSE_NS = 2000;
  localparam int POR_PULSE_CYCLES = (POR_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int RC_TICK_NS = 10000;
  localparam int RC_TICK_CYCLES = RC_TICK_NS / CLK_PERIOD_NS;
  localparam int DELAY_MS = 72;
  localparam int DELAY_TICKS_DEFAULT = DELAY_MS * 1000000 / RC_TICK_NS;
  localparam int SETTLE_CYCLES = 1024;
  localparam int EXT_FILTER_NS = 200;
  localparam int EXT_FILTER_CYCLES = (EXT_FILTER_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int OSC_FILTER_CYCLES = 1;

  // Counter widths
  localparam int POR_CNT_W = 6;
  localparam int RC_DIV_W = 8;
  localparam int DELAY_CNT_W = 16;
  localparam int SETTLE_CNT_W = 11;
  localparam int FILT_CNT_W = 4;
  localparam int PC_W = 13;

  // Register byte addresses
  localparam logic [7:0] ADDR_PWR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_STATUS = 8'h04;
  localparam logic [7:0] ADDR_SEQ = 8'h08;
  localparam logic [7:0] ADDR_PC = 8'h0c;

  // Field positions
  localparam int PWR_CTRL_POR_BIT = 1;
  localparam int STAT_TO_BIT = 4;
  localparam int STAT_PDOWN_BIT = 3;
  localparam int SEQ_STATE_LSB = 0;
  localparam int SEQ_CAUSE_LSB = 4;
  localparam int SEQ_CORE_RST_BIT = 8;
  localparam int SEQ_HOLD_BIT = 9;
  localparam int SEQ_DELAY_DONE_BIT = 10;
  localparam int SEQ_SETTLE_DONE_BIT = 11;
  localparam int SEQ_DELAY_EN_N_BIT = 12;
  localparam int SEQ_MODE_LSB = 13;

  // Reset values and vectors
  localparam logic [7:0] PWR_CTRL_RESET = 8'h00;
  localparam logic [7:0] STATUS_POR_VALUE = 8'h18;
  localparam logic [PC_W-1:0] PC_RESET_VECTOR = 13'h0000;
  localparam logic [PC_W-1:0] PC_IRQ_VECTOR = 13'h0004;

  typedef enum logic [1:0] {
    OSC_LP, OSC_XT, OSC_HS, OSC_RC
  } pursq_osc_mode_type;

  typedef enum logic [2:0] {
    ST_SUPPLY_LOW, ST_POR_PULSE, ST_DELAY, ST_SETTLE, ST_PIN_WAIT, ST_RUN, ST_SLEEP, ST_WAKE_SETTLE
  } pursq_state_type;

  typedef enum logic [2:0] {
    CAUSE_NONE, CAUSE_POR, CAUSE_EXT_RUN, CAUSE_EXT_SLEEP, CAUSE_WDT_RST, CAUSE_WDT_WAKE, CAUSE_IRQ_WAKE
  } pursq_cause_type;

  typedef struct packed {
    logic cyc;
    logic stb;
    logic we;
    logic [7:0] adr;
    logic [3:0] sel;
    logic [31:0] dat;
  } pursq_wb_req_type;

  typedef struct packed {
    logic ack;
    logic [31:0] dat;
  } pursq_wb_rsp_type;

  typedef struct packed {
    logic sleeping;
    logic wdt_timeout;
    logic irq_wake;
    logic global_irq_enable;
    logic [PC_W-1:0] cur_pc;
  } pursq_core_evt_type;

endpackage

// File: verilog/pursq_pin_sync.sv
// Three-stage pin synchroniser with a stability filter
`timescale 1ns/100ps
module pursq_pin_sync
  import pursq_pkg::*;
#(
  parameter int FILT = 1
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rstn,
  // Pin and filtered level
  input wire logic pin,
  output logic level
);

  typedef struct packed {
    logic s1;
    logic s2;
    logic s3;
    logic lvl;
    logic [FILT_CNT_W-1:0] cnt;
  } pursq_sync_state_type;

  pursq_sync_state_type r_reg;
  pursq_sync_state_type r_next;

  always_comb begin
    r_next = r_reg;
    r_next.s1 = pin;
    r_next.s2 = r_reg.s1;
    r_next.s3 = r_reg.s2;
    // Accept a change only after FILT agreeing samples
    if (r_reg.s2 != r_reg.s3 || r_reg.s3 == r_reg.lvl) begin
      r_next.cnt = '0;
    end else if (r_reg.cnt == FILT_CNT_W'(FILT - 1)) begin
      r_next.lvl = r_reg.s3;
      r_next.cnt = '0;
    end else begin
      r_next.cnt = r_reg.cnt + 1'b1;
    end
  end

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      r_reg <= '0;
    end else begin
      r_reg <= r_next;
    end
  end

  assign level = r_reg.lvl;

endmodule

// File: verilog/pursq_stage_timer.sv
// Start-once stage timer that counts tick enables to a terminal count
`timescale 1ns/100ps
module pursq_stage_timer
  import pursq_pkg::*;
#(
  parameter int W = 16
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rstn,
  // Control
  input wire logic start,
  input wire logic tick,
  input wire logic [W-1:0] term,
  // Status
  output logic busy,
  output logic done
);

  typedef struct packed {
    logic [W-1:0] cnt;
    logic busy;
    logic done;
  } pursq_timer_state_type;

  pursq_timer_state_type r_reg;
  pursq_timer_state_type r_next;

  always_comb begin
    r_next = r_reg;
    if (start) begin
      r_next.cnt = '0;
      r_next.busy = 1'b1;
      r_next.done = 1'b0;
    end else if (r_reg.busy && tick) begin
      r_next.cnt = r_reg.cnt + 1'b1;
      if (r_reg.cnt + 1'b1 == term) begin
        r_next.busy = 1'b0;
        r_next.done = 1'b1;
      end
    end
  end

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      r_reg <= '0;
    end else begin
      r_reg <= r_next;
    end
  end

  assign busy = r_reg.busy;
  assign done = r_reg.done;

endmodule

// File: verilog/pursq_top.sv
// Power-up reset sequencer: supply pulse, power-up delay, oscillator settle, reset cause
// Function
// - Supply rise makes an internal power-on pulse
// - Fixed power-up delay only after power-on
// - Power-up delay runs from internal RC tick
// - Core held in reset while delay counts
// - Configuration bit skips the power-up delay
// - Then count 1024 oscillator cycles before release
// - Oscillator count only crystal modes, power-on, wake
// - Stages run pulse, delay, oscillator count
// - RC mode: none or fixed delay only
// - Crystal modes: 1024 periods, plus delay if enabled
// - Stages ignore pin; late pin release runs immediately
// - Power-on flag clears on power-on; software sets
// - Power-on sets time-out and power-down flags
// - Flags encode watchdog, pin and wake causes
// - Program counter zero on reset, next or interrupt vector on wake
// - Status register takes value per reset cause
// - Watchdog never drives pin; pin is filtered
`timescale 1ns/100ps
module pursq_top
  import pursq_pkg::*;
#(
  parameter int DELAY_TICKS = DELAY_TICKS_DEFAULT
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rstn,
  // Wishbone slave
  input wire pursq_wb_req_type wb_req,
  output pursq_wb_rsp_type wb_rsp,
  // Pins and analog detector
  input wire logic supply_ok,
  input wire logic ext_reset_n,
  input wire logic osc_input,
  // Nonvolatile configuration
  input wire logic powerup_delay_enable_n,
  input wire pursq_osc_mode_type osc_mode,
  // Core side
  input wire pursq_core_evt_type core_evt,
  output logic core_reset_n,
  output logic core_hold,
  output logic pc_load,
  output logic [PC_W-1:0] pc_value
);

  typedef struct packed {
    pursq_state_type st;
    pursq_cause_type cause;
    logic [POR_CNT_W-1:0] por_cnt;
    logic [RC_DIV_W-1:0] rc_div;
    logic supply_prev;
    logic osc_prev;
    logic por_flag;
    logic [7:0] status;
    logic [PC_W-1:0] pc;
    logic pc_load;
    logic core_rst;
    logic hold;
    logic ack;
    logic [31:0] rdat;
  } pursq_main_state_type;

  pursq_main_state_type r_reg;
  pursq_main_state_type r_next;

  logic supply_lvl;
  logic ext_lvl;
  logic osc_lvl;
  logic rc_tick;
  logic osc_edge;
  logic dly_start;
  logic stl_start;
  logic dly_busy;
  logic dly_done;
  logic stl_busy;
  logic stl_done;

  function automatic logic is_crystal(input pursq_osc_mode_type m);
    return m != OSC_RC;
  endfunction

  function automatic logic [7:0] status_with_flags(input logic [7:0] s, input logic bank_clear,
                                                   input logic to_v, input logic pd_v);
    logic [7:0] v;
    v = s;
    if (bank_clear) begin
      v[7:5] = 3'h0;
    end
    v[STAT_TO_BIT] = to_v;
    v[STAT_PDOWN_BIT] = pd_v;
    return v;
  endfunction

  // Pin inputs through filtered synchronisers
  pursq_pin_sync #(
    .FILT(OSC_FILTER_CYCLES)
  ) u_supply_sync (
    .sys_clk(sys_clk),
    .rstn(rstn),
    .pin(supply_ok),
    .level(supply_lvl)
  );

  pursq_pin_sync #(
    .FILT(EXT_FILTER_CYCLES)
  ) u_ext_sync (
    .sys_clk(sys_clk),
    .rstn(rstn),
    .pin(ext_reset_n),
    .level(ext_lvl)
  );

  pursq_pin_sync #(
    .FILT(OSC_FILTER_CYCLES)
  ) u_osc_sync (
    .sys_clk(sys_clk),
    .rstn(rstn),
    .pin(osc_input),
    .level(osc_lvl)
  );

  // dedicated RC tick, not the oscillator
  assign rc_tick = (r_reg.rc_div == RC_DIV_W'(RC_TICK_CYCLES - 1));
  assign osc_edge = osc_lvl & ~r_reg.osc_prev;

  pursq_stage_timer #(
    .W(DELAY_CNT_W)
  ) u_powerup_delay_timer (
    .sys_clk(sys_clk),
    .rstn(rstn),
    .start(dly_start),
    .tick(rc_tick),
    .term(DELAY_CNT_W'(DELAY_TICKS)),
    .busy(dly_busy),
    .done(dly_done)
  );

  pursq_stage_timer #(
    .W(SETTLE_CNT_W)
  ) u_osc_settle_counter (
    .sys_clk(sys_clk),
    .rstn(rstn),
    .start(stl_start),
    .tick(osc_edge),
    .term(SETTLE_CNT_W'(SETTLE_CYCLES)),
    .busy(stl_busy),
    .done(stl_done)
  );

  always_comb begin
    r_next = r_reg;
    dly_start = 1'b0;
    stl_start = 1'b0;
    r_next.pc_load = 1'b0;
    r_next.supply_prev = supply_lvl;
    r_next.osc_prev = osc_lvl;
    r_next.rc_div = rc_tick ? '0 : r_reg.rc_div + 1'b1;

    // Register bus: one-cycle ack, write and read at the same edge
    r_next.ack = wb_req.cyc & wb_req.stb & ~r_reg.ack;
    r_next.rdat = '0;
    if (wb_req.cyc && wb_req.stb && !r_reg.ack) begin
      if (wb_req.we && wb_req.sel[0]) begin
        if (wb_req.adr == ADDR_PWR_CTRL) begin
          r_next.por_flag = wb_req.dat[PWR_CTRL_POR_BIT];
        end else if (wb_req.adr == ADDR_STATUS) begin
          r_next.status = wb_req.dat[7:0];
        end
      end
      unique case (wb_req.adr)
        ADDR_PWR_CTRL: r_next.rdat[PWR_CTRL_POR_BIT] = r_reg.por_flag;
        ADDR_STATUS: r_next.rdat[7:0] = r_reg.status;
        ADDR_SEQ: begin
          r_next.rdat[SEQ_STATE_LSB +: 3] = r_reg.st;
          r_next.rdat[SEQ_CAUSE_LSB +: 3] = r_reg.cause;
          r_next.rdat[SEQ_CORE_RST_BIT] = r_reg.core_rst;
          r_next.rdat[SEQ_HOLD_BIT] = r_reg.hold;
          r_next.rdat[SEQ_DELAY_DONE_BIT] = dly_done;
          r_next.rdat[SEQ_SETTLE_DONE_BIT] = stl_done;
          r_next.rdat[SEQ_DELAY_EN_N_BIT] = powerup_delay_enable_n;
          r_next.rdat[SEQ_MODE_LSB +: 2] = osc_mode;
        end
        ADDR_PC: r_next.rdat[PC_W-1:0] = r_reg.pc;
        default: r_next.rdat = '0;
      endcase
    end

    unique case (r_reg.st)
      ST_SUPPLY_LOW: begin
        // supply rise starts the power-on pulse
        if (supply_lvl && !r_reg.supply_prev) begin
          r_next.st = ST_POR_PULSE;
          r_next.por_cnt = '0;
          r_next.cause = CAUSE_POR;
          // power-on clears the flag, beating a write
          r_next.por_flag = 1'b0;
          r_next.status = STATUS_POR_VALUE;
          r_next.pc = PC_RESET_VECTOR;
        end
      end
      ST_POR_PULSE: begin
        r_next.por_cnt = r_reg.por_cnt + 1'b1;
        // pulse first, then delay, then settle count
        if (r_reg.por_cnt == POR_CNT_W'(POR_PULSE_CYCLES - 1)) begin
          // enable bit selects the delay stage
          if (!powerup_delay_enable_n) begin
            dly_start = 1'b1;
            r_next.st = ST_DELAY;
          // crystal without delay: settle count only
          end else if (is_crystal(osc_mode)) begin
            stl_start = 1'b1;
            r_next.st = ST_SETTLE;
          // RC mode without delay: no time-out
          end else begin
            r_next.st = ST_PIN_WAIT;
          end
        end
      end
      ST_DELAY: begin
        // held in reset while the delay counts
        if (dly_done && !dly_busy) begin
          // settle count only in crystal modes
          if (is_crystal(osc_mode)) begin
            stl_start = 1'b1;
            r_next.st = ST_SETTLE;
          end else begin
            r_next.st = ST_PIN_WAIT;
          end
        end
      end
      ST_SETTLE: begin
        if (stl_done && !stl_busy) begin
          r_next.st = ST_PIN_WAIT;
        end
      end
      ST_PIN_WAIT: begin
        // late pin release starts at once
        if (ext_lvl) begin
          r_next.st = ST_RUN;
          r_next.pc_load = 1'b1;
        end
      end
      ST_RUN: begin
        if (!ext_lvl) begin
          // pin reset while running: flags kept
          r_next.status[7:5] = 3'h0;
          r_next.cause = CAUSE_EXT_RUN;
          r_next.pc = PC_RESET_VECTOR;
          r_next.st = ST_PIN_WAIT;
        end else if (core_evt.wdt_timeout) begin
          r_next.status = status_with_flags(r_reg.status, 1'b1, 1'b0, 1'b1);
          r_next.cause = CAUSE_WDT_RST;
          r_next.pc = PC_RESET_VECTOR;
          r_next.st = ST_PIN_WAIT;
        end else if (core_evt.sleeping) begin
          r_next.st = ST_SLEEP;
        end
      end
      ST_SLEEP: begin
        if (!ext_lvl) begin
          // pin reset in sleep: time-out 1, power-down 0
          r_next.status = status_with_flags(r_reg.status, 1'b1, 1'b1, 1'b0);
          r_next.cause = CAUSE_EXT_SLEEP;
          r_next.pc = PC_RESET_VECTOR;
          r_next.st = ST_PIN_WAIT;
        end else if (core_evt.wdt_timeout || core_evt.irq_wake) begin
          r_next.status = status_with_flags(r_reg.status, 1'b0, ~core_evt.wdt_timeout, 1'b0);
          r_next.cause = core_evt.wdt_timeout ? CAUSE_WDT_WAKE : CAUSE_IRQ_WAKE;
          // next instruction, or vector on enabled interrupt
          if (!core_evt.wdt_timeout && core_evt.global_irq_enable) begin
            r_next.pc = PC_IRQ_VECTOR;
          end else begin
            r_next.pc = core_evt.cur_pc + 1'b1;
          end
          // wake runs the settle count in crystal modes
          stl_start = is_crystal(osc_mode);
          r_next.st = ST_WAKE_SETTLE;
        end else if (!core_evt.sleeping) begin
          r_next.st = ST_RUN;
        end
      end
      ST_WAKE_SETTLE: begin
        if (!ext_lvl) begin
          r_next.status = status_with_flags(r_reg.status, 1'b1, 1'b1, 1'b0);
          r_next.cause = CAUSE_EXT_SLEEP;
          r_next.pc = PC_RESET_VECTOR;
          r_next.st = ST_PIN_WAIT;
        // wake costs 1024 periods in crystal modes
        end else if (!is_crystal(osc_mode) || (stl_done && !stl_busy && !stl_start)) begin
          r_next.pc_load = 1'b1;
          r_next.st = ST_RUN;
        end
      end
      default: r_next.st = ST_SUPPLY_LOW;
    endcase

    // Supply loss restarts everything
    if (!supply_lvl) begin
      r_next.st = ST_SUPPLY_LOW;
    end

    // reset held by pulse, pin, delay or settle stage
    r_next.core_rst = (r_next.st == ST_SUPPLY_LOW) || (r_next.st == ST_POR_PULSE) ||
                      (r_next.st == ST_DELAY) || (r_next.st == ST_SETTLE) || (r_next.st == ST_PIN_WAIT);
    r_next.hold = (r_next.st == ST_WAKE_SETTLE);
  end

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      r_reg <= '0;
      r_reg.st <= ST_SUPPLY_LOW;
      r_reg.cause <= CAUSE_NONE;
      r_reg.por_flag <= PWR_CTRL_RESET[PWR_CTRL_POR_BIT];
      r_reg.status <= STATUS_POR_VALUE;
      r_reg.pc <= PC_RESET_VECTOR;
      r_reg.core_rst <= 1'b1;
    end else begin
      r_reg <= r_next;
    end
  end

  assign wb_rsp.ack = r_reg.ack;
  assign wb_rsp.dat = r_reg.rdat;
  assign core_reset_n = ~r_reg.core_rst;
  assign core_hold = r_reg.hold;
  assign pc_load = r_reg.pc_load;
  assign pc_value = r_reg.pc;

endmodule

// File: test/pursq_top_asserts.sv
// Port assertions for the power-up reset sequencer
`timescale 1ns/100ps
module pursq_top_asserts
  import pursq_pkg::*;
#(
  parameter int DELAY_TICKS = DELAY_TICKS_DEFAULT
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rstn,
  // Register bus
  input wire pursq_wb_req_type wb_req,
  input wire pursq_wb_rsp_type wb_rsp,
  // Pins and configuration
  input wire logic supply_ok,
  input wire logic ext_reset_n,
  input wire logic osc_input,
  input wire logic powerup_delay_enable_n,
  input wire pursq_osc_mode_type osc_mode,
  // Core side
  input wire pursq_core_evt_type core_evt,
  input wire logic core_reset_n,
  input wire logic core_hold,
  input wire logic pc_load,
  input wire logic [PC_W-1:0] pc_value
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rstn);

  sequence s_wdt_in_run;
    core_evt.wdt_timeout && core_reset_n && !core_hold && ext_reset_n && supply_ok && !core_evt.sleeping
      && !$past(core_evt.sleeping) && !$past(core_evt.sleeping, 2);
  endsequence
  sequence s_short_reset;
    !core_reset_n ##1 (core_reset_n && pc_load && pc_value == '0);
  endsequence

  a_ack_next_cycle: assert property (wb_req.cyc && wb_req.stb && !wb_rsp.ack |=> wb_rsp.ack)
    else $error("bus request not answered in one cycle");
  a_ack_single: assert property (wb_rsp.ack |=> !wb_rsp.ack)
    else $error("ack longer than one cycle");
  a_dat_idle_zero: assert property (!wb_rsp.ack |-> wb_rsp.dat == '0)
    else $error("read data without ack");
  a_supply_drop: assert property ($fell(supply_ok) |-> ##[1:6] !core_reset_n)
    else $error("supply loss did not reset core");
  a_pin_low_reset: assert property ((!ext_reset_n) [*8] |-> ##[0:4] !core_reset_n)
    else $error("low pin did not hold core reset");
  a_release_loads_pc: assert property ($rose(core_reset_n) |-> pc_load && pc_value == '0)
    else $error("reset release without zero pc load");
  a_load_one_cycle: assert property (pc_load |=> !pc_load)
    else $error("pc load longer than one cycle");
  a_wdt_short_reset: assert property (s_wdt_in_run |=> s_short_reset)
    else $error("watchdog reset pulse wrong");
  a_rc_wake_fast: assert property ($rose(core_hold) && osc_mode == OSC_RC |-> ##[1:2] ($fell(core_hold) && pc_load))
    else $error("rc wake not released promptly");
  a_xtal_wake_hold: assert property ($rose(core_hold) && osc_mode != OSC_RC |-> core_hold [*8])
    else $error("crystal wake released too soon");
endmodule

bind pursq_top pursq_top_asserts #(.DELAY_TICKS(DELAY_TICKS)) i_pursq_top_asserts (.sys_clk(sys_clk), .rstn(rstn),
  .wb_req(wb_req), .wb_rsp(wb_rsp), .supply_ok(supply_ok), .ext_reset_n(ext_reset_n), .osc_input(osc_input),
  .powerup_delay_enable_n(powerup_delay_enable_n), .osc_mode(osc_mode), .core_evt(core_evt),
  .core_reset_n(core_reset_n), .core_hold(core_hold), .pc_load(pc_load), .pc_value(pc_value));

// File: test/pursq_far_side.sv
// Model of the supply rail, reset pin driver and crystal
`timescale 1ns/100ps
module pursq_far_side (
  // Bench controls
  power_on,
  pin_low,
  // Device pins
  supply_ok,
  ext_reset_n,
  osc_input
);
  input wire logic power_on;
  input wire logic pin_low;
  output logic supply_ok;
  output logic ext_reset_n;
  output logic osc_input = 1'b0;
  assign supply_ok = power_on;
  // Pin held low while conditions unmet
  assign ext_reset_n = !pin_low;
  // Free-running crystal, 3.125 MHz
  always #160 osc_input = !osc_input;
endmodule

// File: test/pursq_top_tb.sv
// Testbench for the power-up reset sequencer
`timescale 1ns/100ps
module pursq_top_tb;
  import pursq_pkg::*;
  logic sys_clk = 1'b0;
  logic rstn = 1'b0;
  pursq_wb_req_type wb_req = '0;
  pursq_wb_rsp_type wb_rsp;
  pursq_core_evt_type core_evt = '0;
  pursq_osc_mode_type osc_mode = OSC_XT;
  logic powerup_delay_enable_n = 1'b0;
  logic power_on = 1'b0;
  logic pin_low = 1'b0;
  logic supply_ok, ext_reset_n, osc_input, core_reset_n, core_hold, pc_load;
  logic [PC_W-1:0] pc_value;
  int mismatches = 0;
  int n_compared = 0;

  pursq_top #(.DELAY_TICKS(4)) i_pursq_top (.sys_clk(sys_clk), .rstn(rstn), .wb_req(wb_req), .wb_rsp(wb_rsp),
    .supply_ok(supply_ok), .ext_reset_n(ext_reset_n), .osc_input(osc_input),
    .powerup_delay_enable_n(powerup_delay_enable_n), .osc_mode(osc_mode), .core_evt(core_evt),
    .core_reset_n(core_reset_n), .core_hold(core_hold), .pc_load(pc_load), .pc_value(pc_value));
  pursq_far_side i_pursq_far_side (.power_on(power_on), .pin_low(pin_low), .supply_ok(supply_ok),
    .ext_reset_n(ext_reset_n), .osc_input(osc_input));

  always #20 sys_clk = !sys_clk;

  task automatic report_and_stop;
    $display("Compared %0d, mismatches %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      mismatches++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
    int n;
    n = 0;
    wb_req <= '{cyc: 1'b1, stb: 1'b1, we: w, adr: a, sel: 4'hf, dat: d};
    @(posedge sys_clk);
    while (wb_rsp.ack !== 1'b1 && n < 20) begin
      @(posedge sys_clk);
      n++;
    end
    q = wb_rsp.dat;
    wb_req <= '0;
    if (n >= 20) mismatches++;
    @(posedge sys_clk);
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] q;
    wb(1'b0, a, 32'h0, q);
    chk(q, exp);
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    wb(1'b1, a, d, q);
  endtask

  // Watch for the load pulse from the event on; a pin pulse ends after 13 cycles
  task automatic wait_load(input int mx);
    int n;
    n = 0;
    while (pc_load !== 1'b1 && n < mx) begin
      if (n == 12) pin_low <= 1'b0;
      @(posedge sys_clk);
      n++;
    end
    pin_low <= 1'b0;
    chk({31'h0, pc_load}, 32'h1);
  endtask

  // Power cycle; low at lo_at, released within hi_by more cycles
  task automatic pcyc(input pursq_osc_mode_type m, input logic pn, input int lo_at, input int hi_by);
    logic [31:0] q;
    int n;
    power_on <= 1'b0;
    osc_mode <= m;
    powerup_delay_enable_n <= pn;
    repeat (8) @(posedge sys_clk);
    power_on <= 1'b1;
    repeat (lo_at) @(posedge sys_clk);
    chk({31'h0, core_reset_n}, 32'h0);
    if (pin_low === 1'b1) begin
      wb(1'b0, ADDR_SEQ, 32'h0, q);
      chk({29'h0, q[2:0]}, {29'h0, ST_PIN_WAIT});
      pin_low <= 1'b0;
    end
    n = 0;
    while (core_reset_n !== 1'b1 && n < hi_by) begin
      @(posedge sys_clk);
      n++;
    end
    chk({31'h0, core_reset_n}, 32'h1);
  endtask

  // Core event: sleep, watchdog, interrupt, enable, pc, pin pulse
  task automatic ev(input logic s, input logic w, input logic i, input logic g, input logic [12:0] pc,
                    input logic pin, input int mx);
    core_evt.sleeping <= s;
    core_evt.global_irq_enable <= g;
    core_evt.cur_pc <= pc;
    repeat (3) @(posedge sys_clk);
    pin_low <= pin;
    core_evt.wdt_timeout <= w;
    core_evt.irq_wake <= i;
    @(posedge sys_clk);
    core_evt.wdt_timeout <= 1'b0;
    core_evt.irq_wake <= 1'b0;
    wait_load(mx);
    core_evt.sleeping <= 1'b0;
  endtask

  initial begin
    repeat (2) @(posedge sys_clk);
    rstn <= 1'b1;
    @(posedge sys_clk);
    rd(ADDR_PWR_CTRL, 32'h0);
    rd(ADDR_STATUS, 32'h18);
    wr(8'h10, 32'hff);
    rd(8'h10, 32'h0);
    pin_low <= 1'b1;
    pcyc(OSC_XT, 1'b0, 9600, 14);
    chk(pc_value, 32'h0);
    rd(ADDR_STATUS, 32'h18);
    rd(ADDR_PWR_CTRL, 32'h0);
    wr(ADDR_PWR_CTRL, 32'hff);
    rd(ADDR_PWR_CTRL, 32'h2);
    pcyc(OSC_LP, 1'b1, 8100, 400);
    rd(ADDR_PWR_CTRL, 32'h0);
    pcyc(OSC_HS, 1'b0, 8900, 450);
    ev(1'b1, 1'b1, 1'b0, 1'b0, 13'h123, 1'b0, 9000);
    chk(pc_value, 32'h124);
    rd(ADDR_STATUS, 32'h00);
    pcyc(OSC_RC, 1'b0, 780, 350);
    pcyc(OSC_RC, 1'b1, 30, 60);
    wr(ADDR_PWR_CTRL, 32'h2);
    wr(ADDR_STATUS, 32'he7);
    ev(1'b0, 1'b0, 1'b0, 1'b0, 13'h0, 1'b1, 40);
    chk(pc_value, 32'h0);
    rd(ADDR_STATUS, 32'h07);
    rd(ADDR_PWR_CTRL, 32'h2);
    ev(1'b0, 1'b1, 1'b0, 1'b0, 13'h0, 1'b0, 10);
    chk(pc_value, 32'h0);
    rd(ADDR_STATUS, 32'h0f);
    ev(1'b1, 1'b1, 1'b0, 1'b0, 13'h123, 1'b0, 10);
    chk(pc_value, 32'h124);
    rd(ADDR_STATUS, 32'h07);
    ev(1'b1, 1'b0, 1'b1, 1'b1, 13'h050, 1'b0, 10);
    chk(pc_value, 32'h004);
    rd(ADDR_STATUS, 32'h17);
    ev(1'b1, 1'b0, 1'b1, 1'b0, 13'h0fff, 1'b0, 10);
    chk(pc_value, 32'h1000);
    wr(ADDR_STATUS, 32'he7);
    ev(1'b1, 1'b0, 1'b0, 1'b0, 13'h050, 1'b1, 40);
    chk(pc_value, 32'h0);
    rd(ADDR_STATUS, 32'h17);
    report_and_stop();
  end

  initial begin
    #(100000 * 40);
    mismatches++;
    report_and_stop();
  end
endmodule
